// *** pkg/asf_consts.vh ***
// constants for the squitter message framer
`ifndef ASF_CONSTS_VH
`define ASF_CONSTS_VH

// ****************************************
// frame layout
// ****************************************
`define ASF_FRAME_W        112
`define ASF_ME_W           56
`define ASF_AA_W           24
`define ASF_TC_W           5
`define ASF_DF_EXT         5'h11
`define ASF_CA_DEFAULT     3'h5
`define ASF_CRC_POLY       24'hfff409

// ****************************************
// message kinds (one-hot request slots)
// ****************************************
`define ASF_NKIND          8
`define ASF_K_APOS         0
`define ASF_K_SPOS         1
`define ASF_K_IDENT        2
`define ASF_K_VEL          3
`define ASF_K_STAT         4
`define ASF_K_TSS          5
`define ASF_K_OPST         6
`define ASF_K_AUX          7

// ****************************************
// type and subtype codes
// ****************************************
`define ASF_TC_VEL         5'h13
`define ASF_TC_STAT        5'h1c
`define ASF_TC_TSS         5'h1d
`define ASF_TC_OPST        5'h1f
`define ASF_ST_TSS         3'h1
`define ASF_ST_EMERG       3'h1
`define ASF_ST_RA          3'h2
`define ASF_ST_OP_AIR      3'h0
`define ASF_ST_OP_SURF     3'h1
`define ASF_VERSION        3'h2
`define ASF_CONSPIC        13'h0200

// ****************************************
// repetition periods in ms, and in cycles
// ****************************************
`define ASF_CLK_HZ         40000000
`define ASF_P_POS_MS       500
`define ASF_P_VEL_MS       500
`define ASF_P_IDENT_MS     5000
`define ASF_P_STAT_MS      1000
`define ASF_P_TSS_MS       1250
`define ASF_P_OPST_MS      2500
`define ASF_P_AUX_MS       5000
`define ASF_CYC(ms)        ((ms) * (`ASF_CLK_HZ / 1000))

`endif

// *** verilog/asf_skid_buffer.v ***
// two-entry buffer between the framer and the transmitter
`timescale 1ns/1ps

module asf_skid_buffer #(
   parameter W = 112
) (
   input  wire         ref_clk,   // clock
   input  wire         rstn,      // async reset, low
   input  wire [W-1:0] in_data,   // word in
   input  wire         in_valid,  // word in valid
   output wire         in_ready,  // room for a word
   output wire [W-1:0] out_data,  // word out
   output wire         out_valid, // word out valid
   input  wire         out_ready  // sink takes word
);

   reg [W-1:0] mem_reg [0:1];
   reg         wp_reg;
   reg         rp_reg;
   reg [1:0]   cnt_reg;

   wire push = in_valid && (cnt_reg != 2'h2);
   wire pop  = out_ready && (cnt_reg != 2'h0);

   assign in_ready  = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data  = mem_reg[rp_reg];

   // pointers and fill count; push and pop may share a cycle
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (push)
            wp_reg <= ~wp_reg;
         if (pop)
            rp_reg <= ~rp_reg;
         if (push && !pop)
            cnt_reg <= cnt_reg + 2'h1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 2'h1;
      end
   end

   // storage needs no reset, valid gates it
   always @(posedge ref_clk) begin
      if (push)
         mem_reg[wp_reg] <= in_data;
   end

endmodule // asf_skid_buffer

// *** verilog/asf_squitter_framer.v ***
// extended squitter frame builder with per-kind repetition scheduling
//
// How it works
// - payload lands in the 56-bit ME field, frame bits 33 to 88.
// - the 24-bit aircraft address fills frame bits 9 to 32 of every frame.
// - first five ME bits hold the type code naming the payload kind.
// - position type codes carry containment category; airborne 0,9-18,20-22, surface 0,5-8.
// - identification frames use type code 1 to 4, no subtype.
// - velocity frames use type code 19, subtype 1 normal or 2 supersonic.
// - status frames use type 28; subtype 1 emergency, subtype 2 advisory.
// - target state frames use type 29 with subtype 1.
// - operational status uses type 31; subtype 0 airborne, 1 surface.
// - operational status version field is the fixed constant 2.
// - squitter and reply data come from one shared input.
// - auxiliary registers 07 and 0A are also framed and sent.
// - supplement A rides in operational status, supplement B in airborne position.
// - each kind repeats at its own period, not a common one.
// - mode A code 1000 stops mode A broadcasting.
// - integrity failure forces both NIC and NACp to zero.
`timescale 1ns/1ps
`include "asf_consts.vh"

module asf_squitter_framer #(
   parameter [31:0] POS_CYC   = `ASF_CYC(`ASF_P_POS_MS),
   parameter [31:0] VEL_CYC   = `ASF_CYC(`ASF_P_VEL_MS),
   parameter [31:0] IDENT_CYC = `ASF_CYC(`ASF_P_IDENT_MS),
   parameter [31:0] STAT_CYC  = `ASF_CYC(`ASF_P_STAT_MS),
   parameter [31:0] TSS_CYC   = `ASF_CYC(`ASF_P_TSS_MS),
   parameter [31:0] OPST_CYC  = `ASF_CYC(`ASF_P_OPST_MS),
   parameter [31:0] AUX_CYC   = `ASF_CYC(`ASF_P_AUX_MS)
) (
   input  wire         ref_clk,        // 40 MHz clock
   input  wire         rstn,           // async reset, low
   input  wire [23:0]  aircraft_addr,  // 24-bit aircraft address
   input  wire         on_surface,     // air/ground state, pin
   input  wire [50:0]  apos_body,      // airborne position, ME bits 6..56
   input  wire [4:0]   apos_nic_tc,    // airborne type code from NIC
   input  wire         apos_upd,       // airborne position update strobe
   input  wire [50:0]  spos_body,      // surface position body
   input  wire [4:0]   spos_nic_tc,    // surface type code from NIC
   input  wire         spos_upd,       // surface position update strobe
   input  wire         pos_integ_fail, // position source integrity failure
   input  wire         nic_supp_b,     // supplement B for airborne position
   input  wire [1:0]   ident_tc_sel,   // identification type code 1..4 less one
   input  wire [50:0]  ident_body,     // category and characters
   input  wire         ident_upd,      // identification update strobe
   input  wire [47:0]  vel_body,       // velocity body after subtype
   input  wire         vel_supersonic, // supersonic velocity encoding
   input  wire         vel_upd,        // velocity update strobe
   input  wire [12:0]  mode_a_code,    // shared mode A code, also for replies
   input  wire [2:0]   emerg_state,    // shared emergency state
   input  wire         ra_active,      // advisory broadcast in place of mode A
   input  wire [47:0]  ra_body,        // advisory body after subtype
   input  wire         stat_upd,       // status update strobe
   input  wire [47:0]  tss_body,       // target state body
   input  wire         tss_upd,        // target state update strobe
   input  wire [44:0]  opst_body,      // op status body, less version and supps
   input  wire         nic_supp_a,     // supplement A
   input  wire [3:0]   nacp_in,        // NACp from source
   input  wire         opst_upd,       // op status update strobe
   input  wire [55:0]  aux_reg07,      // register 07 payload
   input  wire [55:0]  aux_reg0a,      // register 0A payload
   input  wire         aux_upd,        // auxiliary update strobe
   output reg  [111:0] frame_data,     // finished frame, bit 1 is msb
   output reg          frame_valid,    // frame present
   input  wire         frame_ready     // transmitter takes the frame
);

   // ****************************************
   // input synchronisers for the pin levels
   // ****************************************
   reg [1:0] surf_sync_reg;
   reg [1:0] fail_sync_reg;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         surf_sync_reg <= 2'h0;
         fail_sync_reg <= 2'h0;
      end else begin
         surf_sync_reg <= {surf_sync_reg[0], on_surface};
         fail_sync_reg <= {fail_sync_reg[0], pos_integ_fail};
      end
   end
   wire surf_s = surf_sync_reg[1];
   wire fail_s = fail_sync_reg[1];

   // ****************************************
   // payload latches
   // ****************************************
   // whole payloads copied in one edge; only the op status subtype is taken live from air/ground at framing
   reg [55:0] apos_reg, spos_reg, ident_reg, vel_reg, stat_reg, tss_reg, opst_reg;
   reg [55:0] aux07_reg, aux0a_reg;
   reg        aux_sel_reg;   // alternates 07 and 0A
   reg        mode_a_on_reg; // mode A broadcast enabled

   wire [4:0] apos_tc = fail_s ? 5'h00 : apos_nic_tc;
   wire [4:0] spos_tc = fail_s ? 5'h00 : spos_nic_tc;
   wire [3:0] nacp_eff = fail_s ? 4'h0 : nacp_in;
   wire [2:0] vel_st = vel_supersonic ? 3'h2 : 3'h1;
   wire [2:0] op_st = surf_s ? `ASF_ST_OP_SURF : `ASF_ST_OP_AIR;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         apos_reg      <= 56'h0;
         spos_reg      <= 56'h0;
         ident_reg     <= 56'h0;
         vel_reg       <= 56'h0;
         stat_reg      <= 56'h0;
         tss_reg       <= 56'h0;
         opst_reg      <= 56'h0;
         aux07_reg     <= 56'h0;
         aux0a_reg     <= 56'h0;
         mode_a_on_reg <= 1'b0;
      end else begin
         if (apos_upd)
            apos_reg <= {apos_tc, apos_body[50:45], nic_supp_b, apos_body[43:0]};
         if (spos_upd)
            spos_reg <= {spos_tc, spos_body};
         if (ident_upd)
            ident_reg <= {2'h0, {1'b0, ident_tc_sel} + 3'h1, ident_body};
         if (vel_upd)
            vel_reg <= {`ASF_TC_VEL, vel_st, vel_body};
         if (stat_upd) begin
            mode_a_on_reg <= (mode_a_code != `ASF_CONSPIC);
            if (ra_active)
               stat_reg <= {`ASF_TC_STAT, `ASF_ST_RA, ra_body};
            else
               stat_reg <= {`ASF_TC_STAT, `ASF_ST_EMERG, emerg_state,
                            mode_a_code, 32'h0};
         end
         if (tss_upd)
            tss_reg <= {`ASF_TC_TSS, `ASF_ST_TSS, tss_body};
         if (opst_upd)
            opst_reg <= {`ASF_TC_OPST, op_st, opst_body[44:21], `ASF_VERSION,
                         nic_supp_a, nacp_eff, opst_body[15:0]};
         if (aux_upd) begin
            aux07_reg <= aux_reg07;
            aux0a_reg <= aux_reg0a;
         end
      end
   end

   // ****************************************
   // repetition timers, one per kind
   // ****************************************
   reg  [31:0] period [0:`ASF_NKIND-1];
   wire [`ASF_NKIND-1:0] kind_en;
   reg  [`ASF_NKIND-1:0] pend_reg;
   reg  [`ASF_NKIND-1:0] grant;

   always @* begin
      period[`ASF_K_APOS]  = POS_CYC;
      period[`ASF_K_SPOS]  = POS_CYC;
      period[`ASF_K_IDENT] = IDENT_CYC;
      period[`ASF_K_VEL]   = VEL_CYC;
      period[`ASF_K_STAT]  = STAT_CYC;
      period[`ASF_K_TSS]   = TSS_CYC;
      period[`ASF_K_OPST]  = OPST_CYC;
      period[`ASF_K_AUX]   = AUX_CYC;
   end

   // surface kinds only on ground; mode A status only when not conspicuity
   assign kind_en = {1'b1, 1'b1, 1'b1, mode_a_on_reg | ra_active, ~surf_s, 1'b1,
                     surf_s, ~surf_s};

   genvar g;
   generate
      for (g = 0; g < `ASF_NKIND; g = g + 1) begin : g_tmr
         reg [31:0] cnt_reg;
         // a pending slot waits for the framer; the timer keeps running
         always @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               cnt_reg     <= 32'h0;
               pend_reg[g] <= 1'b0;
            end else begin
               if (cnt_reg >= period[g] - 32'h1)
                  cnt_reg <= 32'h0;
               else
                  cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= period[g] - 32'h1 && kind_en[g])
                  pend_reg[g] <= 1'b1;
               else if (grant[g])
                  pend_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************
   // arbiter and frame assembly
   // ****************************************
   localparam ST_IDLE = 2'b01;
   localparam ST_SEND = 2'b10;
   reg [1:0]   state_reg;
   reg [111:0] asm_reg;
   reg         asm_valid_reg;
   wire        buf_ready;
   reg  [55:0] me_sel;
   integer     i;

   // lowest index wins; position first, then identification, then velocity
   always @* begin
      grant = {`ASF_NKIND{1'b0}};
      for (i = `ASF_NKIND - 1; i >= 0; i = i - 1) begin
         if (pend_reg[i])
            grant = ({{(`ASF_NKIND-1){1'b0}}, 1'b1} << i);
      end
      if (state_reg != ST_IDLE)
         grant = {`ASF_NKIND{1'b0}};
   end

   always @* begin
      me_sel = 56'h0;
      if (grant[`ASF_K_APOS])
         me_sel = apos_reg;
      else if (grant[`ASF_K_SPOS])
         me_sel = spos_reg;
      else if (grant[`ASF_K_IDENT])
         me_sel = ident_reg;
      else if (grant[`ASF_K_VEL])
         me_sel = vel_reg;
      else if (grant[`ASF_K_STAT])
         me_sel = stat_reg;
      else if (grant[`ASF_K_TSS])
         me_sel = tss_reg;
      else if (grant[`ASF_K_OPST])
         me_sel = {opst_reg[55:51], op_st, opst_reg[47:0]};
      else if (grant[`ASF_K_AUX])
         me_sel = aux_sel_reg ? aux0a_reg : aux07_reg;
   end

   // parity over the 88 leading bits, remainder of the 24-bit generator
   function [23:0] crc88;
      input [87:0] d;
      reg   [23:0] r;
      integer      k;
      begin
         r = 24'h0;
         for (k = 87; k >= 0; k = k - 1) begin
            if (d[k] ^ r[23])
               r = {r[22:0], 1'b0} ^ `ASF_CRC_POLY;
            else
               r = {r[22:0], 1'b0};
         end
         crc88 = r;
      end
   endfunction

   wire [87:0] head = {`ASF_DF_EXT, `ASF_CA_DEFAULT, aircraft_addr, me_sel};

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg     <= ST_IDLE;
         asm_reg       <= 112'h0;
         asm_valid_reg <= 1'b0;
         aux_sel_reg   <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (|grant) begin
                  asm_reg       <= {head, crc88(head)};
                  asm_valid_reg <= 1'b1;
                  state_reg     <= ST_SEND;
                  if (grant[`ASF_K_AUX])
                     aux_sel_reg <= ~aux_sel_reg;
               end
            end
            ST_SEND: begin
               if (buf_ready) begin
                  asm_valid_reg <= 1'b0;
                  state_reg     <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // output buffer and registered outputs
   // ****************************************
   wire [111:0] buf_data;
   wire         buf_valid;
   wire         out_take = frame_ready && frame_valid;
   wire         buf_pop  = buf_valid && (!frame_valid || out_take);

   asf_skid_buffer #(.W(`ASF_FRAME_W)) u_buf (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .in_data   (asm_reg),
      .in_valid  (asm_valid_reg),
      .in_ready  (buf_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (buf_pop)
   );

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         frame_data  <= 112'h0;
         frame_valid <= 1'b0;
      end else begin
         if (buf_pop) begin
            frame_data  <= buf_data;
            frame_valid <= 1'b1;
         end else if (out_take) begin
            frame_valid <= 1'b0;
         end
      end
   end

endmodule // asf_squitter_framer

// *** testbench/asf_framer_checker.sv ***
// concurrent checks on the squitter framer ports
`timescale 1ns/1ps

module asf_framer_checker (
   input wire         ref_clk,       // clock
   input wire         rstn,          // async reset, low
   input wire [23:0]  aircraft_addr, // address in
   input wire         on_surface,    // air/ground pin
   input wire [111:0] frame_data,    // frame out
   input wire         frame_valid,   // frame present
   input wire         frame_ready    // frame taken
);
   wire [4:0] tc = frame_data[79:75];
   wire [2:0] st = frame_data[74:72];
   reg        surf_reg;
   reg  [4:0] calm_reg;

   // cycles since air/ground last moved; pin is synchronised and frames queue
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         surf_reg <= 1'b0;
         calm_reg <= 5'h00;
      end else begin
         surf_reg <= on_surface;
         if (on_surface != surf_reg)
            calm_reg <= 5'h00;
         else if (calm_reg != 5'h1f)
            calm_reg <= calm_reg + 5'h01;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   chk_hdr_fields: assert property (frame_valid |-> frame_data[111:104] == 8'h8d)
      else $error("format or capability field wrong");
   chk_addr_field: assert property (frame_valid |-> frame_data[103:80] == aircraft_addr)
      else $error("address field differs from address input");
   chk_stall_hold: assert property (
      frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
      else $error("frame changed or dropped while stalled");
   chk_vel_subtype: assert property (
      frame_valid && tc == 5'h13 |-> st == 3'h1 || st == 3'h2)
      else $error("velocity subtype out of range");
   chk_stat_subtype: assert property (
      frame_valid && tc == 5'h1c |-> st == 3'h1 || st == 3'h2)
      else $error("status subtype out of range");
   chk_tss_subtype: assert property (frame_valid && tc == 5'h1d |-> st == 3'h1)
      else $error("target state subtype wrong");
   chk_opst_version: assert property (
      frame_valid && tc == 5'h1f |-> frame_data[47:45] == 3'h2)
      else $error("version field wrong");
   chk_opst_surface: assert property (
      frame_valid && tc == 5'h1f && calm_reg > 5'h17 |-> st == {2'h0, on_surface})
      else $error("operational status subtype disagrees with air/ground");
endmodule // asf_framer_checker

bind asf_squitter_framer asf_framer_checker u_checker (
   .ref_clk(ref_clk), .rstn(rstn), .aircraft_addr(aircraft_addr), .on_surface(on_surface),
   .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready)
);

// *** testbench/asf_tx_model.sv ***
// transmitter model taking finished frames, promptly or with stalls
`timescale 1ns/1ps

module asf_tx_model (
   input  wire       ref_clk,     // clock
   input  wire       rstn,        // async reset, low
   input  wire [1:0] pace,        // 0 prompt, 1 slow, 2 hold
   output reg        frame_ready  // frame taken
);
   reg [1:0] tick_reg;

   // slow takes one slot in four; hold refuses everything to fill the queue
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tick_reg    <= 2'h0;
         frame_ready <= 1'b0;
      end else begin
         tick_reg    <= tick_reg + 2'h1;
         frame_ready <= (pace == 2'h0) || (pace == 2'h1 && tick_reg == 2'h3);
      end
   end
endmodule // asf_tx_model

// *** testbench/adsb_squitter_message_framer_test.sv ***
// self-checking bench for the squitter framer
`timescale 1ns/1ps

module adsb_squitter_message_framer_test;
   reg          ref_clk, rstn, upd, on_surface, pos_integ_fail, nic_supp_a, nic_supp_b;
   reg          vel_supersonic, ra_active, live;
   reg  [1:0]   ident_tc_sel, pace;
   reg  [2:0]   emerg_state;
   reg  [4:0]   apos_nic_tc, spos_nic_tc;
   reg  [3:0]   nacp_in;
   reg  [7:0]   want;
   reg  [12:0]  mode_a_code;
   reg  [23:0]  aircraft_addr;
   reg  [44:0]  opst_body;
   reg  [47:0]  vel_body, ra_body, tss_body;
   reg  [50:0]  apos_body, spos_body, ident_body;
   reg  [55:0]  aux_reg07, aux_reg0a;
   reg  [55:0]  exp_me [0:8];
   reg  [38:0]  rows [0:3];
   reg  [63:0]  pat;
   wire [111:0] frame_data;
   wire         frame_valid, frame_ready;
   integer      n_errors, num_checks, cyc, i, j, kind, last_aux, bad;
   integer      cnt [0:7];
   localparam P_POS = 64, P_VEL = 72, P_IDENT = 80, P_STAT = 88;
   localparam P_TSS = 96, P_OPST = 104, P_AUX = 112;
   int          per [0:7] = '{P_POS, P_POS, P_IDENT, P_VEL, P_STAT, P_TSS, P_OPST, P_AUX};

   asf_squitter_framer #(.POS_CYC(P_POS), .VEL_CYC(P_VEL), .IDENT_CYC(P_IDENT),
      .STAT_CYC(P_STAT), .TSS_CYC(P_TSS), .OPST_CYC(P_OPST), .AUX_CYC(P_AUX)) dut (
      .ref_clk(ref_clk), .rstn(rstn), .aircraft_addr(aircraft_addr), .on_surface(on_surface),
      .apos_body(apos_body), .apos_nic_tc(apos_nic_tc), .apos_upd(upd), .spos_body(spos_body),
      .spos_nic_tc(spos_nic_tc), .spos_upd(upd), .pos_integ_fail(pos_integ_fail),
      .nic_supp_b(nic_supp_b), .ident_tc_sel(ident_tc_sel), .ident_body(ident_body),
      .ident_upd(upd), .vel_body(vel_body), .vel_supersonic(vel_supersonic), .vel_upd(upd),
      .mode_a_code(mode_a_code), .emerg_state(emerg_state), .ra_active(ra_active),
      .ra_body(ra_body), .stat_upd(upd), .tss_body(tss_body), .tss_upd(upd),
      .opst_body(opst_body), .nic_supp_a(nic_supp_a), .nacp_in(nacp_in), .opst_upd(upd),
      .aux_reg07(aux_reg07), .aux_reg0a(aux_reg0a), .aux_upd(upd), .frame_data(frame_data),
      .frame_valid(frame_valid), .frame_ready(frame_ready));

   asf_tx_model u_tx (.ref_clk(ref_clk), .rstn(rstn), .pace(pace), .frame_ready(frame_ready));

   task check(input [111:0] got, input [111:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task conclude;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   // parity over the first 88 frame bits, msb first
   function [23:0] parity(input [87:0] d);
      integer b;
      begin
         parity = 24'h000000;
         for (b = 87; b >= 0; b = b - 1)
            parity = {parity[22:0], 1'b0} ^ ((d[b] ^ parity[23]) ? 24'hfff409 : 24'h000000);
      end
   endfunction

   task set_bodies(input [63:0] p);
      begin
         apos_body = p[50:0];
         spos_body = p[63:13];
         ident_body = p[55:5];
         vel_body = p[47:0];
         ra_body = p[63:16];
         tss_body = p[57:10];
         opst_body = p[44:0];
         aux_reg07 = {5'h17, p[50:0]};
         aux_reg0a = {5'h18, p[63:13]};
      end
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // a stuck design must not hang the run
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         conclude;
      end
   end

   // each frame taken while live is rebuilt from the latched inputs and compared whole
   always @(posedge ref_clk) begin
      if (frame_valid && frame_ready) begin
         case (frame_data[79:75])
            5'h00: kind = on_surface ? 1 : 0;
            5'h01, 5'h02, 5'h03, 5'h04: kind = 2;
            5'h05, 5'h06, 5'h07, 5'h08: kind = 1;
            5'h13: kind = 3;
            5'h1c: kind = 4;
            5'h1d: kind = 5;
            5'h1f: kind = 6;
            5'h17: kind = 7;
            5'h18: kind = 8;
            default: kind = 0;
         endcase
         if (live) begin
            check(frame_data, {8'h8d, aircraft_addr, exp_me[kind],
               parity({8'h8d, aircraft_addr, exp_me[kind]})});
            cnt[kind > 7 ? 7 : kind] = cnt[kind > 7 ? 7 : kind] + 1;
         end
         if (kind > 6) begin
            check(kind != last_aux, 1'b1);
            last_aux = kind;
         end
      end
   end

   initial begin
      // air/ground, failure, ident sel, supersonic, advisory, mode A, position codes, pace, kinds
      rows[0] = {1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 13'h0a3b, 5'h0b, 5'h06, 2'h0, 8'hfd};
      rows[1] = {1'b1, 1'b0, 2'h1, 1'b1, 1'b1, 13'h0200, 5'h12, 5'h05, 2'h1, 8'hf6};
      rows[2] = {1'b0, 1'b1, 2'h2, 1'b0, 1'b0, 13'h0200, 5'h14, 5'h07, 2'h0, 8'hed};
      rows[3] = {1'b1, 1'b1, 2'h3, 1'b1, 1'b0, 13'h1fff, 5'h09, 5'h08, 2'h1, 8'hf6};
      {n_errors, num_checks, cyc, last_aux} = {32'd0, 32'd0, 32'd0, 32'd8};
      {rstn, upd, live, nic_supp_a, nic_supp_b, nacp_in, emerg_state} = 12'h000;
      aircraft_addr = 24'h4b1d27;
      {on_surface, pos_integ_fail, ident_tc_sel, vel_supersonic, ra_active,
         mode_a_code, apos_nic_tc, spos_nic_tc, pace, want} = rows[0];
      set_bodies(64'h0);
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      check(frame_valid, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
         live = 1'b0;
         pace = 2'h0;
         repeat (16) @(negedge ref_clk);
         {on_surface, pos_integ_fail, ident_tc_sel, vel_supersonic, ra_active,
            mode_a_code, apos_nic_tc, spos_nic_tc, pace, want} = rows[i];
         pat = 64'hc3a5_9617_e2d4_0b8f ^ {16{i[3:0]}};
         nic_supp_a = pat[9];
         nic_supp_b = ~pat[44];
         nacp_in = pat[7:4];
         emerg_state = pat[2:0];
         set_bodies(pat);
         exp_me[0] = {pos_integ_fail ? 5'h00 : apos_nic_tc, apos_body[50:45], nic_supp_b,
            apos_body[43:0]};
         exp_me[1] = {pos_integ_fail ? 5'h00 : spos_nic_tc, spos_body};
         exp_me[2] = {5'h01 + {3'h0, ident_tc_sel}, ident_body};
         exp_me[3] = {5'h13, vel_supersonic ? 3'h2 : 3'h1, vel_body};
         exp_me[4] = ra_active ? {5'h1c, 3'h2, ra_body} :
            {5'h1c, 3'h1, emerg_state, mode_a_code, 32'h0};
         exp_me[5] = {5'h1d, 3'h1, tss_body};
         exp_me[6] = {5'h1f, 2'h0, on_surface, opst_body[44:21], 3'h2, nic_supp_a,
            pos_integ_fail ? 4'h0 : nacp_in, opst_body[15:0]};
         exp_me[7] = aux_reg07;
         exp_me[8] = aux_reg0a;
         repeat (8) @(negedge ref_clk);
         upd = 1'b1;
         @(negedge ref_clk);
         upd = 1'b0;
         // raw inputs move on; frames must keep the latched words
         set_bodies(~pat);
         repeat (24) @(negedge ref_clk);
         for (j = 0; j < 8; j = j + 1)
            cnt[j] = 0;
         live = 1'b1;
         repeat (400) @(negedge ref_clk);
         live = 1'b0;
         for (j = 0; j < 8; j = j + 1)
            check(want[j] ? (cnt[j] >= 400 / per[j] - 1 && cnt[j] <= 400 / per[j] + 1) :
               (cnt[j] == 0), 1'b1);
      end
      // long stall: the queue fills and the frame on offer must stand
      live = 1'b1;
      pace = 2'h2;
      repeat (300) @(negedge ref_clk);
      check(frame_valid, 1'b1);
      pace = 2'h0;
      repeat (60) @(negedge ref_clk);
      // reset in mid-run: outputs drop and stay quiet for less than one period
      live = 1'b0;
      rstn = 1'b0;
      repeat (2) @(negedge ref_clk);
      check(frame_valid, 1'b0);
      rstn = 1'b1;
      bad = 0;
      repeat (40) begin
         @(negedge ref_clk);
         if (frame_valid !== 1'b0)
            bad = 1;
      end
      check(bad, 0);
      conclude;
   end
endmodule // adsb_squitter_message_framer_test
